/* File: core/bplf_framing.sv */
/*
  Biphase line framing: transmit sequencer and receive decoder for the coax,
  multiplexed coax, twinax and general 8-bit modes, with a transmit FIFO.
  Assumes a 25 MHz reference clock, a static mode while a message is on the
  line, and an external line driver that releases the wire on line_oe_n high.
*/
// Notes on behaviour
// R1: Coax modes run at 2.3587 MHz.
// R2: Twinax mode runs at 1 MHz.
// R3: Multiplexed coax sends eight-bit address frame first.
// R4: Coax: rising centre is one, falling zero.
// R5: Twinax: falling centre is one, rising zero.
// R6: Start violation: low 1.5 bits, high 1.5.
// R7: Twinax start violation uses inverted levels.
// R8: Coax ends: zero, rising edge, two mini-violations.
// R9: Twinax frames separated by zero fill bits.
// R10: Twinax transmitter holds line after the message.
// R11: General mode: 8-bit frames, optional address filtering.
// R12: Holding registers are first-in first-out.
// R13: Mini-violation: whole bit high, not twinax.
// R14: Five quiesce ones, violation, then sync bit.
// R15: Every frame starts with a sync one.
// R16: Serial logic ticks at eight times bit rate.
// R17: Receiver realigns on centres, detects missing centres.
`timescale 1ns/1ps
`default_nettype none
module bplf_framing #(
  parameter int         DATA_W     = 8,
  parameter int         FIFO_DEPTH = 8,
  parameter logic [7:0] HOLD_BITS  = 8'h10
) (
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic [1:0]        mode,
  input  wire logic              tx_start,
  input  wire logic [7:0]        tx_addr,
  input  wire logic [7:0]        fill_bits,
  input  wire logic [DATA_W-1:0] tx_data,
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  output logic                   tx_busy,
  input  wire logic              line_i,
  output logic                   line_o,
  output logic                   line_oe_n,
  input  wire logic [7:0]        rx_addr,
  input  wire logic              rx_promisc,
  output logic [7:0]             rx_data,
  output logic                   rx_valid,
  output logic                   rx_is_addr,
  output logic [2:0]             rx_port,
  output logic                   rx_err,
  output logic                   rx_active
);
  typedef enum logic [6:0] {
    TX_IDLE = 7'h01, TX_QUIESCE = 7'h02, TX_VIOL = 7'h04, TX_FRAME = 7'h08,
    TX_FILL = 7'h10, TX_END = 7'h20, TX_HOLD = 7'h40
  } bplf_tx_t;
  typedef enum logic [2:0] {RX_HUNT = 3'h1, RX_CV = 3'h2, RX_BITS = 3'h4} bplf_rx_t;

  // Biphase half-bit level: the second half carries the bit, polarity by mode.
  function automatic logic enc(input logic b, input logic inv, input logic [4:0] ph);
    return (ph < bplf_pkg::HALF_TICKS) ? ~(b ^ inv) : (b ^ inv); // [R4] [R5]
  endfunction : enc

  function automatic logic twinax(input logic [1:0] m);
    return m == bplf_pkg::MODE_TWINAX;
  endfunction : twinax

  bplf_tx_t              tx_st;
  logic [1:0]            m;
  logic [4:0]            ph;
  logic [7:0]            bit_cnt;
  logic [8:0]            shreg;
  logic                  last_fill;
  logic [bplf_pkg::NCO_W-1:0] nco;
  logic [DATA_W-1:0]     fifo_data;
  logic                  fifo_valid;

  // The oversample tick is a phase accumulator, so both rates come from one clock.
  wire [1:0] rate_mode = (tx_st == TX_IDLE) ? mode : m;
  wire [bplf_pkg::NCO_W-1:0] inc = twinax(rate_mode) ? bplf_pkg::NCO_INC_TWINAX
                                                      : bplf_pkg::NCO_INC_COAX; // [R1] [R2]
  wire [bplf_pkg::NCO_W:0] nco_sum = {1'b0, nco} + {1'b0, inc};
  wire tick = nco_sum[bplf_pkg::NCO_W]; // [R16]

  wire inv       = twinax(m);
  wire addr_mode = (m == bplf_pkg::MODE_MUX) || (m == bplf_pkg::MODE_GP8);
  wire [4:0] sym_len = (tx_st == TX_VIOL || tx_st == TX_END) ? bplf_pkg::CV_TICKS
                                                             : bplf_pkg::BIT_TICKS;
  wire sym_done  = tick && (ph == sym_len - 5'h01);
  wire [7:0] fill_gap = (fill_bits < bplf_pkg::FILL_MIN) ? bplf_pkg::FILL_MIN : fill_bits;
  wire [7:0] fill_tgt = last_fill ? bplf_pkg::FILL_LAST : fill_gap; // [R9]
  wire fill_end  = (tx_st == TX_FILL) && (bit_cnt == fill_tgt - 8'h01);
  wire frame_end = (tx_st == TX_FRAME) && (bit_cnt == bplf_pkg::FRAME_LAST);
  wire use_addr  = (tx_st == TX_VIOL) && addr_mode; // [R3] [R11]
  wire load_frame = sym_done && ((tx_st == TX_VIOL) || (fill_end && !last_fill) ||
                                 (frame_end && fifo_valid && !inv));
  wire fifo_pop  = load_frame && !use_addr;
  wire [7:0] frame_src = use_addr ? tx_addr : 8'(fifo_data);

  bplf_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  logic     next_level;
  bplf_tx_t next_tx_st;
  always_comb begin
    unique case (tx_st)
      TX_QUIESCE: next_level = enc(1'b1, inv, ph); // [R14]
      TX_FRAME:   next_level = enc(shreg[0], inv, ph);
      TX_FILL:    next_level = enc(1'b0, inv, ph); // [R9]
      TX_VIOL:    next_level = (ph < bplf_pkg::CV_HALF_TICKS) ? inv : ~inv; // [R6] [R7]
      TX_END:     next_level = (ph < bplf_pkg::MCV_START) ? enc(1'b0, inv, ph) : 1'b1; // [R8] [R13]
      TX_HOLD:    next_level = 1'b1; // [R10]
      default:    next_level = 1'b0;
    endcase
    next_tx_st = tx_st;
    case (tx_st)
      TX_IDLE:    if (tx_start && fifo_valid) next_tx_st = TX_QUIESCE;
      TX_QUIESCE: if (sym_done && bit_cnt == bplf_pkg::QUIESCE_BITS - 8'h01) next_tx_st = TX_VIOL;
      TX_VIOL:    if (sym_done) next_tx_st = TX_FRAME;
      TX_FRAME: begin
        if (sym_done && frame_end) begin
          next_tx_st = inv ? TX_FILL : (fifo_valid ? TX_FRAME : TX_END);
        end
      end
      TX_FILL:    if (sym_done && fill_end) next_tx_st = last_fill ? TX_HOLD : TX_FRAME;
      TX_END:     if (sym_done) next_tx_st = TX_IDLE;
      TX_HOLD:    if (sym_done && bit_cnt == HOLD_BITS - 8'h01) next_tx_st = TX_IDLE;
      default:    next_tx_st = TX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      nco <= '0;
      ph  <= 5'h00;
    end else begin
      nco <= nco_sum[bplf_pkg::NCO_W-1:0];
      ph  <= (tx_st != next_tx_st || sym_done || tx_st == TX_IDLE) ? 5'h00
           : (tick ? ph + 5'h01 : ph);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_st     <= TX_IDLE;
      m         <= bplf_pkg::MODE_COAX;
      bit_cnt   <= 8'h00;
      shreg     <= 9'h000;
      last_fill <= 1'b0;
    end else begin
      tx_st <= next_tx_st;
      if (tx_st == TX_IDLE) begin
        m <= mode;
      end
      if (load_frame) begin
        shreg <= {frame_src, 1'b1}; // [R15]
      end else if (sym_done && tx_st == TX_FRAME) begin
        shreg <= {1'b0, shreg[8:1]};
      end
      if (sym_done && frame_end) begin
        last_fill <= !fifo_valid;
      end
      bit_cnt <= (tx_st != next_tx_st || load_frame) ? 8'h00
               : (sym_done ? bit_cnt + 8'h01 : bit_cnt);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      line_o    <= 1'b0;
      line_oe_n <= 1'b1;
      tx_busy   <= 1'b0;
    end else begin
      line_o    <= next_level;
      line_oe_n <= tx_st == TX_IDLE; // [R10]
      tx_busy   <= next_tx_st != TX_IDLE;
    end
  end

  // Receive side. The line is asynchronous, so it passes three flops first.
  logic       s1, s2, s3, lvl;
  bplf_rx_t   rx_st;
  logic [5:0] cnt;
  logic [2:0] bitn;
  logic       in_frame;
  logic       first;
  logic       drop;
  logic [7:0] rsh;

  wire rinv    = twinax(mode);
  wire rx_edge = (s2 == s3) && (s3 != lvl);
  wire rbit    = s3 ^ rinv; // [R4] [R5]
  wire in_win  = (cnt >= bplf_pkg::RX_WIN_LO) && (cnt <= bplf_pkg::RX_WIN_HI);
  wire in_sync = (cnt >= bplf_pkg::RX_SYNC_LO) && (cnt <= bplf_pkg::RX_SYNC_HI);
  wire rx_to   = (rx_st == RX_BITS && cnt > bplf_pkg::RX_WIN_HI) ||
                 (rx_st == RX_CV && cnt > bplf_pkg::RX_SYNC_HI); // [R13] [R17]
  wire centre  = rx_edge && ((rx_st == RX_BITS && in_win) || (rx_st == RX_CV && in_sync));
  wire cv_seen = rx_st == RX_HUNT && rx_edge && cnt >= bplf_pkg::RX_CV_MIN && lvl == rinv;
  wire word_done = centre && in_frame && bitn == bplf_pkg::RX_DATA_LAST;
  wire [7:0] word = {rbit, rsh[7:1]};
  wire rx_addr_mode = (mode == bplf_pkg::MODE_MUX) || (mode == bplf_pkg::MODE_GP8);
  wire addr_word = first && rx_addr_mode; // [R3]
  wire reject = addr_word && mode == bplf_pkg::MODE_GP8 && !rx_promisc && word != rx_addr;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1  <= 1'b0;
      s2  <= 1'b0;
      s3  <= 1'b0;
      lvl <= 1'b0;
    end else begin
      s1  <= line_i;
      s2  <= s1;
      s3  <= s2;
      lvl <= (s2 == s3) ? s3 : lvl;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_st    <= RX_HUNT;
      cnt      <= 6'h00;
      bitn     <= 3'h0;
      in_frame <= 1'b0;
      first    <= 1'b0;
      drop     <= 1'b0;
      rsh      <= 8'h00;
    end else begin
      if (rx_edge && (rx_st == RX_HUNT || centre)) begin
        cnt <= 6'h00; // [R17]
      end else if (tick && cnt != bplf_pkg::RX_CNT_MAX) begin
        cnt <= cnt + 6'h01;
      end
      if (cv_seen) begin
        rx_st <= RX_CV; // [R6] [R7]
      end else if (rx_to || (rx_st == RX_CV && centre && !rbit)) begin
        rx_st <= RX_HUNT;
      end else if (centre) begin
        rx_st <= RX_BITS;
      end
      if (cv_seen) begin
        first    <= 1'b1;
        drop     <= 1'b0;
        in_frame <= 1'b0;
      end else if (centre && !in_frame) begin
        in_frame <= rbit; // [R15]
        bitn     <= 3'h0;
      end else if (centre) begin
        rsh      <= word;
        bitn     <= bitn + 3'h1;
        in_frame <= !word_done;
        first    <= word_done ? 1'b0 : first;
        drop     <= (word_done && reject) ? 1'b1 : drop; // [R11]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_data    <= 8'h00;
      rx_valid   <= 1'b0;
      rx_is_addr <= 1'b0;
      rx_port    <= 3'h0;
      rx_err     <= 1'b0;
      rx_active  <= 1'b0;
    end else begin
      rx_valid   <= word_done && !drop && !reject;
      rx_data    <= word_done ? word : rx_data;
      rx_is_addr <= word_done ? addr_word : rx_is_addr;
      rx_port    <= (word_done && addr_word) ? word[2:0] : rx_port; // [R3]
      rx_err     <= (rx_to && in_frame) || (rx_st == RX_CV && centre && !rbit);
      rx_active  <= rx_st != RX_HUNT;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_quiesce_five;
    (tx_st == TX_QUIESCE && next_tx_st == TX_VIOL) |-> bit_cnt == 8'h04;
  endproperty
  a_quiesce_five: assert property (p_quiesce_five) // [R14]
    else $error("Quiesce run is not five bits.");

  property p_cv_first_half;
    (tx_st == TX_VIOL && ph < 5'h0c) |=> (line_o == inv && !line_oe_n);
  endproperty
  a_cv_first_half: assert property (p_cv_first_half) // [R6]
    else $error("Start violation first half has the wrong level.");

  property p_coax_centre;
    (tx_st == TX_FRAME && !inv && ph >= 5'h04) |=> line_o == $past(shreg[0]);
  endproperty
  a_coax_centre: assert property (p_coax_centre) // [R4]
    else $error("Coax bit second half does not carry the bit.");

  property p_twinax_centre;
    (tx_st == TX_FRAME && inv && ph < 5'h04) |=> line_o == $past(shreg[0]);
  endproperty
  a_twinax_centre: assert property (p_twinax_centre) // [R5]
    else $error("Twinax bit first half is not the bit value.");

  property p_mini_high;
    (tx_st == TX_END && ph >= 5'h08) |=> (line_o && !inv);
  endproperty
  a_mini_high: assert property (p_mini_high) // [R13]
    else $error("Mini violation is not held high in a coax mode.");

  property p_fill_count;
    (tx_st == TX_FILL && next_tx_st != TX_FILL) |-> bit_cnt >= 8'h02;
  endproperty
  a_fill_count: assert property (p_fill_count) // [R9]
    else $error("Fewer than three fill bits sent.");

  property p_hold_drive;
    (tx_st == TX_HOLD && next_tx_st == TX_HOLD) |=> (!line_oe_n && line_o) [*2];
  endproperty
  a_hold_drive: assert property (p_hold_drive) // [R10]
    else $error("Line not driven during hold.");

  property p_sync_first;
    (tx_st == TX_FRAME && bit_cnt == 8'h00) |-> shreg[0];
  endproperty
  a_sync_first: assert property (p_sync_first) // [R15]
    else $error("Frame does not start with a sync one.");

  property p_rx_align;
    centre |=> (cnt <= 6'h01 && rx_st == RX_BITS) or (rx_st == RX_HUNT);
  endproperty
  a_rx_align: assert property (p_rx_align) // [R17]
    else $error("Receiver did not realign on a centre transition.");
endmodule : bplf_framing
`default_nettype wire

/* File: core/bplf_pkg.sv */
/*
  Shared constants for the biphase line framing block: bit rates, symbol
  timing in oversample ticks, sequence lengths and protocol modes.
  Assumes a 25 MHz reference clock and eight oversample ticks per bit.
*/
package bplf_pkg;
  localparam int unsigned REF_CLK_HZ    = 25000000;
  localparam int unsigned COAX_BIT_HZ   = 2358700;
  localparam int unsigned TWINAX_BIT_HZ = 1000000;
  localparam int unsigned OVERSAMPLE    = 8;
  localparam int          NCO_W         = 24;
  localparam logic [NCO_W-1:0] NCO_INC_COAX =
    NCO_W'((64'(COAX_BIT_HZ) * 64'(OVERSAMPLE) << NCO_W) / 64'(REF_CLK_HZ));
  localparam logic [NCO_W-1:0] NCO_INC_TWINAX =
    NCO_W'((64'(TWINAX_BIT_HZ) * 64'(OVERSAMPLE) << NCO_W) / 64'(REF_CLK_HZ));

  typedef enum logic [1:0] {
    MODE_COAX   = 2'h0,
    MODE_MUX    = 2'h1,
    MODE_TWINAX = 2'h2,
    MODE_GP8    = 2'h3
  } bplf_mode_t;

  localparam logic [4:0] HALF_TICKS    = 5'h04;
  localparam logic [4:0] BIT_TICKS     = 5'h08;
  localparam logic [4:0] CV_HALF_TICKS = 5'h0c;
  localparam logic [4:0] CV_TICKS      = 5'h18;
  localparam logic [4:0] END_TICKS     = 5'h18;
  localparam logic [4:0] MCV_START     = 5'h08;
  localparam logic [7:0] QUIESCE_BITS  = 8'h05;
  localparam logic [7:0] FILL_MIN      = 8'h03;
  localparam logic [7:0] FILL_LAST     = 8'h03;
  localparam logic [7:0] FRAME_LAST    = 8'h08;
  localparam logic [5:0] RX_WIN_LO     = 6'h06;
  localparam logic [5:0] RX_WIN_HI     = 6'h0a;
  localparam logic [5:0] RX_SYNC_LO    = 6'h0e;
  localparam logic [5:0] RX_SYNC_HI    = 6'h12;
  localparam logic [5:0] RX_CV_MIN     = 6'h0a;
  localparam logic [5:0] RX_CNT_MAX    = 6'h3f;
  localparam logic [2:0] RX_DATA_LAST  = 3'h7;
endpackage : bplf_pkg

/* File: core/bplf_fifo.sv */
/*
  Transmit holding FIFO with registered full and empty flags.
  Assumes one clock and an active low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module bplf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;

  wire wr = in_valid && in_ready;
  wire rd = out_valid && out_ready;
  wire [CW-1:0] next_count = count + CW'(wr) - CW'(rd);

  assign out_data = mem[rd_ptr];

  always_ff @(posedge ref_clk) begin
    if (wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Words leave in the order they arrived. [R12]
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_ptr    <= wr ? AW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
      rd_ptr    <= rd ? AW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
      count     <= next_count;
      in_ready  <= next_count != CW'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_fifo_order;
    (wr && count == '0) |=> (out_valid && out_data == $past(in_data));
  endproperty
  a_fifo_order: assert property (p_fifo_order) // [R12]
    else $error("First word written is not the first word out.");
endmodule : bplf_fifo
`default_nettype wire

/* File: tb/bplf_line_partner.sv */
/*
  Behavioural cable partner for the biphase line framing block: sends framed
  messages onto the wire and shows a floating wire when nobody drives it.
  Assumes the block drives the wire while line_oe_n is low.
*/
`timescale 1ns/1ps
`default_nettype none
module bplf_line_partner (
  input  wire logic ref_clk,
  input  wire logic line_o,
  input  wire logic line_oe_n,
  output logic      line_i
);
  logic drive = 1'b0;
  logic level = 1'b0;
  logic noise = 1'b0;

  // A released cable has no level, so it toggles every cycle rather than hold one.
  always @(posedge ref_clk) begin
    noise <= ~noise;
  end
  assign line_i = !line_oe_n ? line_o : (drive ? level : noise);

  task automatic send_bit(input logic b, input logic inv, input realtime t);
    level = inv ^ ~b;
    #(t / 2.0);
    level = inv ^ b;
    #(t / 2.0);
  endtask : send_bit

  task automatic send_msg(input logic inv, input logic [15:0] w, input int n,
                          input realtime t);
    drive = 1'b1;
    repeat (5) send_bit(1'b1, inv, t);
    level = inv;
    #(t * 1.5);
    level = ~inv;
    #(t * 1.5);
    for (int f = 0; f < n; f++) begin
      if (f > 0 && inv) repeat (3) send_bit(1'b0, inv, t);
      send_bit(1'b1, inv, t);
      for (int i = 0; i < 8; i++) send_bit(w[f * 8 + i], inv, t);
    end
    repeat (inv ? 3 : 1) send_bit(1'b0, inv, t);
    level = 1'b1;
    #(t * 2.0);
    drive = 1'b0;
  endtask : send_msg

  // Start sequence whose first frame opens with a zero instead of a sync one.
  task automatic send_bad(input logic inv, input realtime t);
    drive = 1'b1;
    repeat (5) send_bit(1'b1, inv, t);
    level = inv;
    #(t * 1.5);
    level = ~inv;
    #(t * 1.5);
    send_bit(1'b0, inv, t);
    level = 1'b1;
    #(t * 2.0);
    drive = 1'b0;
  endtask : send_bad
endmodule : bplf_line_partner
`default_nettype wire

/* File: tb/bplf_framing_test.sv */
/*
  Self-checking testbench for the biphase line framing block: received
  messages in every mode from the cable partner, then reset, address
  filtering and transmit loopback through the FIFO.
  Assumes the partner echoes the block's own line while it drives.
*/
`timescale 1ns/1ps
`default_nettype none
module bplf_framing_test;
  localparam real COAX_T = 1.0e9 / bplf_pkg::COAX_BIT_HZ;
  localparam real TWIN_T = 1.0e9 / bplf_pkg::TWINAX_BIT_HZ;
  typedef struct {
    logic [1:0] md;
    logic       addr_first;
    logic [1:0] n;
    logic [7:0] w0;
    logic [7:0] w1;
  } bplf_row_t;

  logic       ref_clk = 1'b0;
  logic       nrst = 1'b0;
  logic [1:0] mode = 2'h0;
  logic       tx_start = 1'b0;
  logic [7:0] tx_addr = 8'h2d;
  logic [7:0] fill_bits = 8'h03;
  logic [7:0] tx_data = 8'h00;
  logic       tx_valid = 1'b0;
  logic       tx_ready;
  logic       tx_busy;
  logic       line_i;
  logic       line_o;
  logic       line_oe_n;
  logic [7:0] rx_addr = 8'h2d;
  logic       rx_promisc = 1'b1;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic       rx_is_addr;
  logic [2:0] rx_port;
  logic       rx_err;
  logic       rx_active;
  int         fails = 0;
  int         tests_run = 0;
  int         low_run = 0;
  int         max_low = 0;
  int         errs = 0;
  int         errs_before = 0;
  logic [8:0] got [$];
  bplf_row_t  rows [5] = '{'{2'h0, 1'b0, 2'h2, 8'h5a, 8'h01},
                           '{2'h1, 1'b1, 2'h2, 8'h06, 8'ha3},
                           '{2'h2, 1'b0, 2'h1, 8'h81, 8'h00},
                           '{2'h2, 1'b0, 2'h2, 8'h3c, 8'hc5},
                           '{2'h3, 1'b1, 2'h2, 8'h2d, 8'hf0}};

  always #20 ref_clk = ~ref_clk;

  bplf_framing #(.HOLD_BITS(8'h02)) i_dut (
    .ref_clk(ref_clk), .nrst(nrst), .mode(mode), .tx_start(tx_start),
    .tx_addr(tx_addr), .fill_bits(fill_bits), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_busy(tx_busy),
    .line_i(line_i), .line_o(line_o), .line_oe_n(line_oe_n),
    .rx_addr(rx_addr), .rx_promisc(rx_promisc), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_is_addr(rx_is_addr), .rx_port(rx_port),
    .rx_err(rx_err), .rx_active(rx_active)
  );

  bplf_line_partner i_line (
    .ref_clk(ref_clk), .line_o(line_o), .line_oe_n(line_oe_n), .line_i(line_i)
  );

  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1) got.push_back({rx_is_addr, rx_data});
    if (rx_err === 1'b1) errs <= errs + 1;
    low_run <= (line_oe_n === 1'b0 && line_o === 1'b0) ? low_run + 1 : 0;
    if (low_run > max_low) max_low <= low_run;
  end

  task automatic end_of_test;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic check_bit(input string name, input logic exp, input logic seen);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, seen);
    end
  endtask : check_bit

  task automatic check_word(input string name, input logic [8:0] exp,
                            input logic [8:0] seen);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check_word

  task automatic check_count(input string name, input int exp, input int seen);
    tests_run++;
    if (seen != exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0d seen %0d", name, exp, seen);
    end
  endtask : check_count

  task automatic run_rx(input bplf_row_t r, input logic accept);
    got.delete();
    @(posedge ref_clk);
    mode <= r.md;
    @(posedge ref_clk);
    i_line.send_msg(r.md == 2'h2, {r.w1, r.w0}, int'(r.n), r.md == 2'h2 ? TWIN_T : COAX_T);
    repeat (30) @(posedge ref_clk);
    check_count("rx words", accept ? int'(r.n) : 0, got.size());
    for (int i = 0; i < got.size() && i < 2; i++)
      check_word("rx word", i == 0 ? {r.addr_first, r.w0} : {1'b0, r.w1}, got[i]);
    if (r.md == 2'h1) check_word("rx port", {6'h00, r.w0[2:0]}, {6'h00, rx_port});
    $display("test rx mode %0d done", r.md);
  endtask : run_rx

  task automatic loop_tx(input logic [1:0] md, input int n);
    @(posedge ref_clk);
    mode <= md;
    fill_bits <= 8'h05;
    for (int k = 0; k < n; k++) begin
      tx_valid <= 1'b1;
      tx_data <= 8'(k * 37 + 5);
      @(posedge ref_clk);
    end
    tx_valid <= 1'b0;
    tx_start <= 1'b1;
    #1;
    check_bit("tx_ready", n < 8, tx_ready);
    got.delete();
    max_low = 0;
    @(posedge ref_clk);
    tx_start <= 1'b0;
    #1;
    check_bit("tx_busy", 1'b1, tx_busy);
    // The line enable follows the state one cycle after the busy flag.
    @(posedge ref_clk);
    #1;
    check_bit("line_oe_n", 1'b0, line_oe_n);
    for (int w = 0; w < 6000 && tx_busy !== 1'b0; w++) @(posedge ref_clk);
    check_bit("tx_busy end", 1'b0, tx_busy);
    repeat (30) @(posedge ref_clk);
    check_count("loop words", n < 8 ? n : 8, got.size());
    for (int k = 0; k < got.size() && k < 8; k++)
      check_word("loop word", {1'b0, 8'(k * 37 + 5)}, got[k]);
    // The longest low run in coax is the violation's first half-and-a-bit.
    if (md == 2'h0) check_bit("cv low run", 1'b1, max_low >= 15 && max_low <= 17);
    $display("test loopback mode %0d done", md);
  endtask : loop_tx

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (rows[r]) run_rx(rows[r], 1'b1);
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check_bit("rst line_oe_n", 1'b1, line_oe_n);
    check_bit("rst line_o", 1'b0, line_o);
    check_bit("rst tx_busy", 1'b0, tx_busy);
    check_bit("rst tx_ready", 1'b1, tx_ready);
    check_bit("rst rx_valid", 1'b0, rx_valid);
    check_bit("rst rx_active", 1'b0, rx_active);
    @(posedge ref_clk);
    nrst <= 1'b1;
    $display("test reset done");
    rx_promisc <= 1'b0;
    run_rx(bplf_row_t'{2'h3, 1'b1, 2'h2, 8'h2e, 8'h77}, 1'b0);
    run_rx(bplf_row_t'{2'h3, 1'b1, 2'h2, 8'h2d, 8'h77}, 1'b1);
    got.delete();
    errs_before = errs;
    i_line.send_bad(1'b0, COAX_T);
    repeat (30) @(posedge ref_clk);
    check_bit("rx_err", 1'b1, errs > errs_before);
    check_count("bad sync words", 0, got.size());
    $display("test bad sync done");
    loop_tx(2'h0, 9);
    loop_tx(2'h2, 3);
    end_of_test();
  end
endmodule : bplf_framing_test
`default_nettype wire
